// ### inc/status_io_pkg.sv
/*
  Package for the status indicator and general purpose pin block:
  register map, field positions, reset values and timing constants.
  Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package status_io_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LINK = 6'h04;
  localparam logic [5:0] OFS_PIN_OE = 6'h08;
  localparam logic [5:0] OFS_PIN_OUT = 6'h0c;
  localparam logic [5:0] OFS_PIN_IN = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_IRQ_EN = 6'h18;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h1c;
  localparam logic [5:0] OFS_INPUTS = 6'h20;

  // Control register fields
  localparam int CTRL_LPM_EN = 0;
  localparam int CTRL_USB2 = 1;
  localparam int CTRL_SUSPEND = 2;
  localparam int CTRL_SS_CONN = 3;
  localparam int CTRL_DISK_BUSY = 4;
  localparam int CTRL_FW_RUN = 5;
  localparam int CTRL_W = 6;

  // Link register: power state code in the low two bits
  localparam int LINK_W = 2;
  localparam logic [1:0] PS_U3 = 2'h0;
  localparam logic [1:0] PS_U2 = 2'h1;
  localparam logic [1:0] PS_U1 = 2'h2;
  localparam logic [1:0] PS_U0 = 2'h3;

  // Spare pins: bits 0..1 power state pins, 2..3 pull-down spares,
  // bit 4 pull-up spare
  localparam int SPARE_W = 5;
  localparam int PS_PIN_LO = 0;
  localparam int PU_PIN = 4;
  localparam logic [4:0] PULLUP_MASK = 5'h10;

  // Status / event bits
  localparam int EV_WAKE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_SRC_CHG = 2;
  localparam int EV_W = 3;

  // Input register fields
  localparam int IN_WAKE = 0;
  localparam int IN_SELF_PWR = 1;
  localparam int IN_FAULT = 2;

  // Timing
  localparam int unsigned HEARTBEAT_MS = 250;
  localparam int unsigned ACT_BLINK_MS = 50;
  localparam logic [31:0] HEARTBEAT_CYC = 32'(CLK_HZ / 1000 * HEARTBEAT_MS);
  localparam logic [31:0] ACT_BLINK_CYC = 32'(CLK_HZ / 1000 * ACT_BLINK_MS);

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [SPARE_W-1:0] oe;
    logic [SPARE_W-1:0] out;
    logic [SPARE_W-1:0] pull_up;
    logic [SPARE_W-1:0] pull_down;
  } pin_drive_type;

endpackage : status_io_pkg

// ### rtl/status_io.sv
/*
  Status indicator and general purpose pin block: indicator outputs,
  filtered board inputs with sticky events, spare pins under software
  control, all over an Avalon-MM slave.
  Assumes board inputs are asynchronous and that the pad cells take
  the pull enables given here.
*/
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
// Function
// - Drive power state code when low-power enabled
// - Otherwise power pins are pulled-down software pins
// - Suspend indicator high while USB2 bus suspended
// - Pulled-down wake input, press requests remote wakeup
// - SuperSpeed indicator high while SuperSpeed connected
// - Pulled-up fault input, low means fault
// - Activity output blinks during disk transfers
// - Heartbeat toggles periodically while firmware runs
// - Pull-down spares reset to inputs, HID-driven outputs
// - Pull-up spare resets to input, HID-driven output
`timescale 1ns/1ps
module status_io #(
  parameter logic [31:0] HEARTBEAT_COUNT = status_io_pkg::HEARTBEAT_CYC,
  parameter logic [31:0] ACT_BLINK_COUNT = status_io_pkg::ACT_BLINK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Board inputs
  input wire logic wake_button,
  input wire logic self_powered,
  input wire logic power_fault_n,
  // Indicators
  output logic suspend_led,
  output logic ss_conn_led,
  output logic disk_act_led,
  output logic heartbeat_led,
  output logic remote_wake_req,
  // Spare pins
  input wire logic [4:0] spare_in,
  output status_io_pkg::pin_drive_type spare_drive,
  // Interrupt
  output logic irq
);

  // Decode of a register offset into a one-hot hit
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  localparam int NSYNC = 3;

  logic [status_io_pkg::CTRL_W-1:0] ctrl_q;
  logic [status_io_pkg::LINK_W-1:0] link_q;
  logic [status_io_pkg::SPARE_W-1:0] pin_oe_q;
  logic [status_io_pkg::SPARE_W-1:0] pin_out_q;
  logic [status_io_pkg::EV_W-1:0] status_q;
  logic [status_io_pkg::EV_W-1:0] status_d;
  logic [status_io_pkg::EV_W-1:0] irq_en_q;
  logic [status_io_pkg::EV_W-1:0] events;
  logic [31:0] readdata_q;
  logic ack_q;
  logic [31:0] hb_cnt_q;
  logic [31:0] act_cnt_q;
  logic hb_q;
  logic act_q;
  logic wake_prev_q;
  logic fault_prev_q;
  logic src_prev_q;
  logic [NSYNC+1:0] prime_q;
  logic wake_req_q;

  // Three-stage synchronisers; a change counts when stages 2 and 3 agree
  logic [NSYNC-1:0] wake_s_q;
  logic [NSYNC-1:0] src_s_q;
  logic [NSYNC-1:0] flt_s_q;
  logic [NSYNC-1:0] spare_s_q [status_io_pkg::SPARE_W];
  logic wake_q;
  logic src_q;
  logic fault_q;
  logic [status_io_pkg::SPARE_W-1:0] spare_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_s_q <= '0;
      src_s_q <= '0;
      flt_s_q <= '1;
      wake_q <= 1'b0;
      src_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      wake_s_q <= {wake_s_q[1:0], wake_button};
      src_s_q <= {src_s_q[1:0], self_powered};
      flt_s_q <= {flt_s_q[1:0], power_fault_n};
      if (wake_s_q[1] == wake_s_q[2]) wake_q <= wake_s_q[2];
      if (src_s_q[1] == src_s_q[2]) src_q <= src_s_q[2];
      if (flt_s_q[1] == flt_s_q[2]) fault_q <= ~flt_s_q[2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < status_io_pkg::SPARE_W; gi++) begin : g_spare
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          spare_s_q[gi] <= '0;
          spare_q[gi] <= 1'b0;
        end else begin
          spare_s_q[gi] <= {spare_s_q[gi][1:0], spare_in[gi]};
          if (spare_s_q[gi][1] == spare_s_q[gi][2]) begin
            spare_q[gi] <= spare_s_q[gi][2];
          end
        end
      end
    end
  endgenerate

  // Bus decode
  wire wr_ctrl = write && hit(address, status_io_pkg::OFS_CTRL);
  wire wr_link = write && hit(address, status_io_pkg::OFS_LINK);
  wire wr_oe = write && hit(address, status_io_pkg::OFS_PIN_OE);
  wire wr_out = write && hit(address, status_io_pkg::OFS_PIN_OUT);
  wire wr_en = write && hit(address, status_io_pkg::OFS_IRQ_EN);
  wire wr_clr = write && hit(address, status_io_pkg::OFS_IRQ_CLR);
  wire lane0 = byteenable[0];
  wire lpm_en = ctrl_q[status_io_pkg::CTRL_LPM_EN];

  // Every access answers one cycle after it is first seen
  assign waitrequest = (read || write) && !ack_q;
  wire take = (read || write) && !ack_q;
  // Writes land on the edge that samples waitrequest low, since only
  // then does the master count the access as done
  wire done = (read || write) && ack_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // spares stay inputs until software drives them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      link_q <= status_io_pkg::PS_U3;
      pin_oe_q <= '0;
      pin_out_q <= '0;
      irq_en_q <= '0;
    end else if (done && lane0) begin
      if (wr_ctrl) ctrl_q <= writedata[status_io_pkg::CTRL_W-1:0];
      if (wr_link) link_q <= writedata[status_io_pkg::LINK_W-1:0];
      if (wr_oe) pin_oe_q <= writedata[status_io_pkg::SPARE_W-1:0];
      if (wr_out) pin_out_q <= writedata[status_io_pkg::SPARE_W-1:0];
      if (wr_en) irq_en_q <= writedata[status_io_pkg::EV_W-1:0];
    end
  end

  // Read mux
  wire [31:0] in_word = {29'h0, fault_q, src_q, wake_q};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = status_io_pkg::ZERO_WORD;
    case (address)
      status_io_pkg::OFS_CTRL: rd_mux = 32'(ctrl_q);
      status_io_pkg::OFS_LINK: rd_mux = 32'(link_q);
      status_io_pkg::OFS_PIN_OE: rd_mux = 32'(pin_oe_q);
      status_io_pkg::OFS_PIN_OUT: rd_mux = 32'(pin_out_q);
      status_io_pkg::OFS_PIN_IN: rd_mux = 32'(spare_q);
      status_io_pkg::OFS_STATUS: rd_mux = 32'(status_q);
      status_io_pkg::OFS_IRQ_EN: rd_mux = 32'(irq_en_q);
      status_io_pkg::OFS_INPUTS: rd_mux = in_word;
      default: rd_mux = status_io_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_q <= '0;
    end else if (take && read) begin
      readdata_q <= rd_mux;
    end
  end
  assign readdata = readdata_q;

  // Edge detection on filtered inputs; source changes are held off until
  // the synchroniser has caught up with a strap already high at reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
      src_prev_q <= 1'b0;
      prime_q <= '0;
    end else begin
      wake_prev_q <= wake_q;
      fault_prev_q <= fault_q;
      src_prev_q <= src_q;
      prime_q <= {prime_q[NSYNC:0], 1'b1};
    end
  end

  // rising press is a wake request
  wire wake_rise = wake_q && !wake_prev_q;
  wire fault_rise = fault_q && !fault_prev_q;
  wire src_chg = prime_q[NSYNC+1] && (src_q != src_prev_q);
  assign events = {src_chg, fault_rise, wake_rise};

  // Set wins over a clear in the same cycle
  wire [status_io_pkg::EV_W-1:0] clr_bits =
    (done && wr_clr && lane0) ? writedata[status_io_pkg::EV_W-1:0] : '0;
  assign status_d = (status_q & ~clr_bits) | events;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= '0;
      wake_req_q <= 1'b0;
    end else begin
      status_q <= status_d;
      wake_req_q <= wake_rise;
    end
  end
  assign irq = |(status_q & irq_en_q);
  assign remote_wake_req = wake_req_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hb_cnt_q <= '0;
      hb_q <= 1'b0;
    end else if (!ctrl_q[status_io_pkg::CTRL_FW_RUN]) begin
      hb_cnt_q <= '0;
    end else if (hb_cnt_q >= HEARTBEAT_COUNT - 32'h1) begin
      hb_cnt_q <= '0;
      hb_q <= ~hb_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + 32'h1;
    end
  end

  // activity blinks while transfers are busy, off when idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_cnt_q <= '0;
      act_q <= 1'b0;
    end else if (!ctrl_q[status_io_pkg::CTRL_DISK_BUSY]) begin
      act_cnt_q <= '0;
      act_q <= 1'b0;
    end else if (act_cnt_q >= ACT_BLINK_COUNT - 32'h1) begin
      act_cnt_q <= '0;
      act_q <= ~act_q;
    end else begin
      act_cnt_q <= act_cnt_q + 32'h1;
    end
  end

  // suspend shown only in USB 2.0 connection
  wire susp_d = ctrl_q[status_io_pkg::CTRL_USB2] &&
    ctrl_q[status_io_pkg::CTRL_SUSPEND];
  wire ss_d = ctrl_q[status_io_pkg::CTRL_SS_CONN];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      suspend_led <= 1'b0;
      ss_conn_led <= 1'b0;
      disk_act_led <= 1'b0;
      heartbeat_led <= 1'b0;
    end else begin
      suspend_led <= susp_d;
      ss_conn_led <= ss_d;
      disk_act_led <= act_q;
      heartbeat_led <= hb_q;
    end
  end

  // power state pins driven by link code; else software pins
  logic [status_io_pkg::SPARE_W-1:0] oe_d;
  logic [status_io_pkg::SPARE_W-1:0] out_d;
  always_comb begin
    oe_d = pin_oe_q;
    out_d = pin_out_q;
    if (lpm_en) begin
      oe_d[status_io_pkg::PS_PIN_LO +: 2] = 2'h3;
      out_d[status_io_pkg::PS_PIN_LO +: 2] = link_q;
    end
  end

  logic [status_io_pkg::SPARE_W-1:0] drv_oe_q;
  logic [status_io_pkg::SPARE_W-1:0] drv_out_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_oe_q <= '0;
      drv_out_q <= '0;
    end else begin
      drv_oe_q <= oe_d;
      drv_out_q <= out_d;
    end
  end
  // pulls fixed per pin group, on whenever not driven
  assign spare_drive = '{oe: drv_oe_q, out: drv_out_q,
    pull_up: status_io_pkg::PULLUP_MASK & ~drv_oe_q,
    pull_down: ~status_io_pkg::PULLUP_MASK & ~drv_oe_q};

  // pins carry the link code one cycle later
  a_ps_code: assert property (@(posedge clk) disable iff (sys_rst)
    $past(lpm_en) |->
      spare_drive.out[1:0] == $past(link_q) && spare_drive.oe[1:0] == 2'h3)
    else $error("power state pins wrong");

  a_ps_release: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(lpm_en) |-> spare_drive.oe[1:0] == $past(pin_oe_q[1:0]))
    else $error("power state pins not released");

  a_suspend_led: assert property (@(posedge clk) disable iff (sys_rst)
    suspend_led == $past(ctrl_q[status_io_pkg::CTRL_USB2] &&
      ctrl_q[status_io_pkg::CTRL_SUSPEND]))
    else $error("suspend indicator wrong");

  sequence wake_press;
    !wake_q ##1 wake_q;
  endsequence
  a_wake_request: assert property (@(posedge clk) disable iff (sys_rst)
    wake_press |=> remote_wake_req ##1 !remote_wake_req)
    else $error("wake request not one pulse");

  a_ss_led: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(ctrl_q[status_io_pkg::CTRL_SS_CONN]) |=> ss_conn_led)
    else $error("superspeed indicator late");

  a_fault_event: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(fault_q) |=> status_q[status_io_pkg::EV_FAULT])
    else $error("fault event lost");

  a_act_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_q[status_io_pkg::CTRL_DISK_BUSY] [*2] |=> !disk_act_led)
    else $error("activity shown while idle");

  a_hb_stop: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_q[status_io_pkg::CTRL_FW_RUN] [*3] |-> $stable(heartbeat_led))
    else $error("heartbeat runs while stopped");

  a_pull_spare: assert property (@(posedge clk) disable iff (sys_rst)
    spare_drive.oe[status_io_pkg::PU_PIN] ==
      $past(pin_oe_q[status_io_pkg::PU_PIN]) &&
      spare_drive.pull_up[status_io_pkg::PU_PIN] ==
      !spare_drive.oe[status_io_pkg::PU_PIN])
    else $error("pull-up spare lost its pull");

  a_reset_idle: assert property (@(posedge clk)
    $fell(sys_rst) |-> spare_drive.oe == '0 && !suspend_led && !ss_conn_led)
    else $error("outputs not idle after reset");

endmodule : status_io

// ### bench/board_model.sv
/*
  Board model: wake button, power strap, fault source and spare pads.
  Assumes the bench sets button, strap and fault levels by clock edge.
*/
`timescale 1ns/1ps
module board_model (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic press,
  input wire logic fault_on,
  input wire logic self_pwr,
  // Block side
  input wire status_io_pkg::pin_drive_type spare_drive,
  output logic wake_button,
  output logic self_powered,
  output logic power_fault_n,
  output logic [4:0] spare_in
);
  // A floating pad wanders, so an unpulled input is never a fixed level
  logic tog_q = 1'h0;
  always_ff @(posedge clk) tog_q <= ~tog_q;
  assign wake_button = press;
  assign self_powered = self_pwr;
  // fault pulled up, low on fault
  assign power_fault_n = ~fault_on;
  for (genvar i = 0; i < 5; i++) begin : g_pad
    assign spare_in[i] = spare_drive.oe[i] ? spare_drive.out[i] :
      spare_drive.pull_up[i] | (~spare_drive.pull_down[i] & tog_q);
  end
endmodule : board_model

// ### bench/bridge_status_indicator_io_tb.sv
/*
  Self-checking bench for the status pin block and its board model.
  Assumes one 50 MHz clock and the Avalon-MM timing of the block.
*/
`timescale 1ns/1ps
module bridge_status_indicator_io_tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [5:0] address = 6'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic press = 1'h0;
  logic fault_on = 1'h0;
  logic self_pwr = 1'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, suspend_led, ss_conn_led, disk_act_led;
  logic heartbeat_led, remote_wake_req, irq;
  logic wake_button, self_powered, power_fault_n;
  logic [4:0] spare_in;
  status_io_pkg::pin_drive_type spare_drive;
  int error_cnt = 0;
  int checked = 0;

  // one steady reference clock for the whole block
  always #10 clk = ~clk;

  status_io #(.HEARTBEAT_COUNT(32'h8), .ACT_BLINK_COUNT(32'h4)) status_io_i (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .wake_button(wake_button), .self_powered(self_powered),
    .power_fault_n(power_fault_n), .suspend_led(suspend_led),
    .ss_conn_led(ss_conn_led), .disk_act_led(disk_act_led),
    .heartbeat_led(heartbeat_led), .remote_wake_req(remote_wake_req),
    .spare_in(spare_in), .spare_drive(spare_drive), .irq(irq));

  board_model board_model_i (.clk(clk), .press(press), .fault_on(fault_on),
    .self_pwr(self_pwr), .spare_drive(spare_drive),
    .wake_button(wake_button), .self_powered(self_powered),
    .power_fault_n(power_fault_n), .spare_in(spare_in));

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'h0) break;
    end
    rd = readdata;
    write <= 1'h0;
    read <= 1'h0;
    if (n == 20) begin
      check("bus_answer", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rdck(input logic [5:0] a, input logic [31:0] e,
                      input string nm);
    bus(1'h0, a, 32'h0);
    check(nm, e, rd);
  endtask : rdck

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_reset_state;
    @(negedge clk);
    check("leds", 32'h0, 32'({suspend_led, ss_conn_led, disk_act_led,
      heartbeat_led, remote_wake_req, irq}));
    check("pins", 32'h20f, 32'(spare_drive));
  endtask : t_reset_state

  task automatic t_pins;
    // Let the pad synchronisers fill after reset
    settle(4);
    rdck(status_io_pkg::OFS_PIN_IN, 32'h10, "pad_pull");
    wr(status_io_pkg::OFS_PIN_OE, 32'h1f);
    wr(status_io_pkg::OFS_PIN_OUT, 32'h0a);
    settle(2);
    check("oe", 32'h1f, 32'(spare_drive.oe));
    check("out", 32'h0a, 32'(spare_drive.out));
    settle(6);
    rdck(status_io_pkg::OFS_PIN_IN, 32'h0a, "pad_drv");
    wr(status_io_pkg::OFS_PIN_OE, 32'h0);
    settle(6);
    rdck(status_io_pkg::OFS_PIN_IN, 32'h10, "pad_rel");
    rdck(6'h24, 32'h0, "unmapped");
  endtask : t_pins

  task automatic t_link;
    wr(status_io_pkg::OFS_CTRL, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(status_io_pkg::OFS_LINK, 32'(c));
      settle(2);
      check("ps_oe", 32'h3, 32'(spare_drive.oe[1:0]));
      check("ps_code", 32'(c), 32'(spare_drive.out[1:0]));
    end
    wr(status_io_pkg::OFS_CTRL, 32'h0);
    wr(status_io_pkg::OFS_PIN_OE, 32'h2);
    wr(status_io_pkg::OFS_PIN_OUT, 32'h2);
    settle(2);
    check("ps_sw", 32'ha, {spare_drive.oe[1:0], spare_drive.out[1:0]});
    wr(status_io_pkg::OFS_PIN_OE, 32'h0);
  endtask : t_link

  task automatic t_leds;
    logic [5:0] cv [4] = '{6'h04, 6'h06, 6'h08, 6'h0e};
    for (int i = 0; i < 4; i++) begin
      wr(status_io_pkg::OFS_CTRL, 32'(cv[i]));
      settle(2);
      check("usb_leds", 32'({cv[i][1] & cv[i][2], cv[i][3]}),
        32'({suspend_led, ss_conn_led}));
    end
  endtask : t_leds

  task automatic edges(input logic hb, output int n);
    logic h;
    n = 0;
    h = hb ? heartbeat_led : disk_act_led;
    repeat (40) begin
      @(negedge clk);
      if ((hb ? heartbeat_led : disk_act_led) !== h) n++;
      h = hb ? heartbeat_led : disk_act_led;
    end
  endtask : edges

  task automatic t_blink;
    int n;
    logic h;
    wr(status_io_pkg::OFS_CTRL, 32'h10);
    edges(1'h0, n);
    check("act_moves", 32'h1, 32'(n >= 2));
    wr(status_io_pkg::OFS_CTRL, 32'h0);
    settle(2);
    check("act_idle", 32'h0, 32'(disk_act_led));
    wr(status_io_pkg::OFS_CTRL, 32'h20);
    edges(1'h1, n);
    check("hb_moves", 32'h1, 32'(n >= 2));
    wr(status_io_pkg::OFS_CTRL, 32'h0);
    settle(2);
    h = heartbeat_led;
    settle(30);
    check("hb_frozen", 32'(h), 32'(heartbeat_led));
  endtask : t_blink

  task automatic t_events;
    int n = 0;
    wr(status_io_pkg::OFS_IRQ_CLR, 32'h7);
    wr(status_io_pkg::OFS_IRQ_EN, 32'h1);
    @(posedge clk);
    press <= 1'h1;
    repeat (20) begin
      @(negedge clk);
      if (remote_wake_req === 1'h1) n++;
    end
    check("wake_pulse", 32'h1, 32'(n));
    @(posedge clk);
    press <= 1'h0;
    settle(8);
    rdck(status_io_pkg::OFS_STATUS, 32'h1, "st_wake");
    check("irq_on", 32'h1, 32'(irq));
    wr(status_io_pkg::OFS_IRQ_CLR, 32'h1);
    settle(1);
    check("irq_off", 32'h0, 32'(irq));
    @(posedge clk);
    fault_on <= 1'h1;
    self_pwr <= 1'h1;
    settle(8);
    rdck(status_io_pkg::OFS_INPUTS, 32'h6, "inputs");
    rdck(status_io_pkg::OFS_STATUS, 32'h6, "st_fault");
    check("irq_mask", 32'h0, 32'(irq));
    @(posedge clk);
    fault_on <= 1'h0;
    settle(8);
    wr(status_io_pkg::OFS_IRQ_CLR, 32'h7);
    rdck(status_io_pkg::OFS_STATUS, 32'h0, "st_clr");
  endtask : t_events

  task automatic t_mid_reset;
    wr(status_io_pkg::OFS_CTRL, 32'h3f);
    wr(status_io_pkg::OFS_PIN_OE, 32'h1f);
    settle(2);
    @(posedge clk);
    sys_rst <= 1'h1;
    t_reset_state();
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    rdck(status_io_pkg::OFS_PIN_OE, 32'h0, "oe_after");
    // Strap is still high here, so a false source event would show
    settle(4);
    rdck(status_io_pkg::OFS_STATUS, 32'h0, "st_after");
  endtask : t_mid_reset

  initial begin
    repeat (3) @(posedge clk);
    t_reset_state();
    repeat (3) @(posedge clk);
    // reset held from time zero; the long hold is scaled down
    sys_rst <= 1'h0;
    t_pins();
    t_link();
    t_leds();
    t_blink();
    t_events();
    t_mid_reset();
    give_verdict();
  end
endmodule : bridge_status_indicator_io_tb
